// [rtl/tls_pkg.sv]
// package: register map, field widths and carriers for the trigger list status block
package tls_pkg;
   // register byte addresses (one aligned word each)
   localparam logic [7:0] TLS_ADDR_GEN1_LIST   = 8'h00;
   localparam logic [7:0] TLS_ADDR_GEN1_COUNT  = 8'h04;
   localparam logic [7:0] TLS_ADDR_GEN1_TVAL   = 8'h08;
   localparam logic [7:0] TLS_ADDR_COUNTER     = 8'h0C;
   localparam logic [7:0] TLS_ADDR_BASE_PTR    = 8'h10;
   localparam logic [7:0] TLS_ADDR_G0L0_OFS    = 8'h14;
   localparam logic [7:0] TLS_ADDR_G0L1_OFS    = 8'h18;
   localparam logic [7:0] TLS_ADDR_G1L0_OFS    = 8'h1C;
   localparam logic [7:0] TLS_ADDR_CTRL        = 8'h20;
   localparam logic [7:0] TLS_ADDR_STATUS      = 8'h24;
   // field widths
   localparam int TLS_CNT_W   = 5;
   localparam int TLS_TV_W    = 16;
   localparam int TLS_PTR_W   = 24;
   localparam int TLS_OFS_W   = 7;
   // control register bit positions
   localparam int TLS_CTRL_GEN0_EN = 0;
   localparam int TLS_CTRL_GEN1_EN = 1;
   // status register bit positions
   localparam int TLS_STAT_GEN0_DONE = 0;
   localparam int TLS_STAT_GEN1_DONE = 1;
   // limits and reset values
   localparam logic [TLS_CNT_W-1:0] TLS_MAX_TRIG_M1 = 5'h1F;
   localparam logic [TLS_TV_W-1:0]  TLS_EOL         = 16'h0000;
   localparam logic [TLS_OFS_W-1:0] TLS_G0L0_VAL    = 7'h00;
   localparam logic [7:0]           TLS_WIN_BYTES_M1 = 8'hFF;
   localparam logic [TLS_PTR_W-1:0] TLS_PTR_RST     = 24'h000000;
   localparam logic [TLS_OFS_W-1:0] TLS_OFS_RST     = 7'h00;

   // list fetch request toward memory
   typedef struct packed {
      logic                 req;
      logic [TLS_PTR_W-1:0] addr;
   } tls_fetch_s;

   // list fetch answer from memory
   typedef struct packed {
      logic                valid;
      logic [TLS_TV_W-1:0] data;
   } tls_fdata_s;

   // trigger generator 1 sequencing
   typedef enum logic [1:0] {
      TLS_IDLE  = 2'b00,
      TLS_FETCH = 2'b01,
      TLS_WAIT  = 2'b10,
      TLS_DONE  = 2'b11
   } tls_state_e;
endpackage

// [rtl/tls_regs.sv]
// trigger list status and list addressing register bank with generator 1 sequencer
`timescale 1ns/1ns

module tls_regs (
   // clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // reload event and generator 0 status
   input  wire logic                          reload,
   input  wire logic                          gen0_done,
   // list one register (gen1 list 1 offset lives elsewhere)
   input  wire logic [tls_pkg::TLS_OFS_W-1:0] gen1_list1_offset,
   // list memory fetch
   output tls_pkg::tls_fetch_s                fetch,
   input  wire tls_pkg::tls_fdata_s           fdata,
   // outputs to the rest of the unit
   output logic                               gen1_trigger,
   output logic                               gen0_enable,
   output logic                               gen1_enable
);
   import tls_pkg::*;

   // registers
   logic                 gen0_en_q, gen0_en_d;         // generator 0 enable
   logic                 gen1_en_q, gen1_en_d;         // generator 1 enable
   logic                 list_q, list_d;               // gen1 active list
   logic [TLS_CNT_W-1:0] count_q, count_d;             // gen1 trigger count
   logic                 max_q, max_d;                 // 32 triggers reached
   logic [TLS_TV_W-1:0]  tval_q, tval_d;               // gen1 next trigger value
   logic [TLS_TV_W-1:0]  cnt_q, cnt_d;                 // time base counter
   logic                 run_q, run_d;                 // counter running
   logic [TLS_PTR_W-1:0] ptr_q, ptr_d;                 // list area base pointer
   logic [TLS_OFS_W-1:0] g0l1_q, g0l1_d;               // gen0 list1 offset
   logic [TLS_OFS_W-1:0] g1l0_q, g1l0_d;               // gen1 list0 offset
   logic [7:0]           idx_q, idx_d;                 // byte index in window
   tls_state_e           st_q, st_d;                   // gen1 sequencer state
   logic                 trig_q, trig_d;               // trigger pulse
   tls_fetch_s           fetch_q, fetch_d;             // fetch request
   logic [31:0]          rdata_q, rdata_d;             // read data
   logic                 ready_q, ready_d;             // apb ready
   logic                 err_q, err_d;                 // apb error

   // decode helper used by read and write paths
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a <= TLS_ADDR_STATUS) && (a[1:0] == 2'b00);
   endfunction

   logic                 wr;                           // write access phase
   logic                 rd;                           // read access phase
   logic                 gen1_done;                    // gen1 finished list or gen1 disabled

   always_comb begin
      wr        = psel && penable && pwrite && !ready_q;
      rd        = psel && penable && !pwrite && !ready_q;
      gen1_done = (st_q == TLS_DONE) || !gen1_en_q;
   end

   // next state for registers, sequencer and bus
   always_comb begin
      gen0_en_d = gen0_en_q;
      gen1_en_d = gen1_en_q;
      list_d    = list_q;
      count_d   = count_q;
      max_d     = max_q;
      tval_d    = tval_q;
      cnt_d     = cnt_q;
      run_d     = run_q;
      ptr_d     = ptr_q;
      g0l1_d    = g0l1_q;
      g1l0_d    = g1l0_q;
      idx_d     = idx_q;
      st_d      = st_q;
      trig_d    = 1'b0;
      fetch_d   = fetch_q;
      rdata_d   = rdata_q;
      ready_d   = 1'b0;
      err_d     = 1'b0;

      // register writes; locked fields keep value silently
      if (wr) begin
         ready_d = 1'b1;
         err_d   = !is_mapped(paddr);
         if (paddr == TLS_ADDR_CTRL) begin
            gen0_en_d = pwdata[TLS_CTRL_GEN0_EN];
            gen1_en_d = pwdata[TLS_CTRL_GEN1_EN];
         end else if (paddr == TLS_ADDR_GEN1_LIST) begin
            if (!gen1_en_q) list_d = pwdata[0];
         end else if (paddr == TLS_ADDR_BASE_PTR) begin
            if (!gen0_en_q && !gen1_en_q) ptr_d = pwdata[TLS_PTR_W-1:0];
         end else if (paddr == TLS_ADDR_G0L1_OFS) begin
            if (!gen0_en_q) g0l1_d = pwdata[TLS_OFS_W-1:0];
         end else if (paddr == TLS_ADDR_G1L0_OFS) begin
            if (!gen1_en_q) g1l0_d = pwdata[TLS_OFS_W-1:0];
         end
      end

      if (rd) begin
         ready_d = 1'b1;
         err_d   = !is_mapped(paddr);
         rdata_d = 32'h0000_0000;
         if (paddr == TLS_ADDR_GEN1_LIST) begin
            rdata_d[0] = list_q;
         end else if (paddr == TLS_ADDR_GEN1_COUNT) begin
            rdata_d[TLS_CNT_W-1:0] = count_q;
         end else if (paddr == TLS_ADDR_GEN1_TVAL) begin
            rdata_d[TLS_TV_W-1:0] = tval_q;
         end else if (paddr == TLS_ADDR_COUNTER) begin
            rdata_d[TLS_TV_W-1:0] = cnt_q;
         end else if (paddr == TLS_ADDR_BASE_PTR) begin
            rdata_d[TLS_PTR_W-1:0] = ptr_q;
         end else if (paddr == TLS_ADDR_G0L0_OFS) begin
            rdata_d[TLS_OFS_W-1:0] = TLS_G0L0_VAL;
         end else if (paddr == TLS_ADDR_G0L1_OFS) begin
            rdata_d[TLS_OFS_W-1:0] = g0l1_q;
         end else if (paddr == TLS_ADDR_G1L0_OFS) begin
            rdata_d[TLS_OFS_W-1:0] = g1l0_q;
         end else if (paddr == TLS_ADDR_CTRL) begin
            rdata_d[TLS_CTRL_GEN0_EN] = gen0_en_q;
            rdata_d[TLS_CTRL_GEN1_EN] = gen1_en_q;
         end else if (paddr == TLS_ADDR_STATUS) begin
            rdata_d[TLS_STAT_GEN0_DONE] = gen0_done;
            rdata_d[TLS_STAT_GEN1_DONE] = (st_q == TLS_DONE);
         end
      end

      // time base counter free runs while active
      if (run_q) cnt_d = cnt_q + 16'h0001;
      if (gen0_done && gen1_done) run_d = 1'b0;

      // generator 1 sequencer
      case (st_q)
         TLS_IDLE: begin
            fetch_d.req = 1'b0;
         end
         TLS_FETCH: begin
            fetch_d.req  = 1'b1;
            fetch_d.addr = ptr_q + {16'h0000, idx_q & TLS_WIN_BYTES_M1};
            if (fdata.valid) begin
               fetch_d.req = 1'b0;
               // zero is end of list, kept visible
               if (fdata.data == TLS_EOL) begin
                  tval_d = fdata.data;
                  st_d   = TLS_DONE;
               end else begin
                  tval_d = fdata.data;
                  idx_d  = idx_q + 8'h02;
                  st_d   = TLS_WAIT;
               end
            end
         end
         TLS_WAIT: begin
            if (cnt_q == tval_q) begin
               trig_d  = 1'b1;
               // count wraps to zero at 32
               count_d = count_q + 5'h01;
               if (count_q == TLS_MAX_TRIG_M1) begin
                  max_d = 1'b1;
                  st_d  = TLS_DONE;
               end else begin
                  st_d = TLS_FETCH;
               end
            end
         end
         TLS_DONE: begin
            fetch_d.req = 1'b0;
         end
         default: st_d = TLS_IDLE;
      endcase

      if (reload && (gen0_en_q || gen1_en_q)) begin
         cnt_d   = 16'h0000;
         run_d   = 1'b1;
         count_d = 5'h00;
         max_d   = 1'b0;
         if (gen1_en_q) begin
            st_d        = TLS_FETCH;
            fetch_d.req = 1'b0;
            idx_d       = list_q ? {1'b0, gen1_list1_offset} : {1'b0, g1l0_q};
         end
      end
      // disabling generator 1 parks its sequencer
      if (!gen1_en_q) begin
         st_d        = TLS_IDLE;
         fetch_d.req = 1'b0;
      end
   end

   // register stage
   always_ff @(posedge core_clk) begin
      if (rst) begin
         gen0_en_q <= 1'b0;
         gen1_en_q <= 1'b0;
         list_q    <= 1'b0;
         count_q   <= 5'h00;
         max_q     <= 1'b0;
         tval_q    <= 16'h0000;
         cnt_q     <= 16'h0000;
         run_q     <= 1'b0;
         ptr_q     <= TLS_PTR_RST;
         g0l1_q    <= TLS_OFS_RST;
         g1l0_q    <= TLS_OFS_RST;
         idx_q     <= 8'h00;
         st_q      <= TLS_IDLE;
         trig_q    <= 1'b0;
         fetch_q   <= '0;
         rdata_q   <= 32'h0000_0000;
         ready_q   <= 1'b0;
         err_q     <= 1'b0;
      end else begin
         gen0_en_q <= gen0_en_d;
         gen1_en_q <= gen1_en_d;
         list_q    <= list_d;
         count_q   <= count_d;
         max_q     <= max_d;
         tval_q    <= tval_d;
         cnt_q     <= cnt_d;
         run_q     <= run_d;
         ptr_q     <= ptr_d;
         g0l1_q    <= g0l1_d;
         g1l0_q    <= g1l0_d;
         idx_q     <= idx_d;
         st_q      <= st_d;
         trig_q    <= trig_d;
         fetch_q   <= fetch_d;
         rdata_q   <= rdata_d;
         ready_q   <= ready_d;
         err_q     <= err_d;
      end
   end

   // outputs straight from flops
   always_comb begin
      prdata       = rdata_q;
      pready       = ready_q;
      pslverr      = err_q;
      fetch        = fetch_q;
      gen1_trigger = trig_q;
      gen0_enable  = gen0_en_q;
      gen1_enable  = gen1_en_q;
   end
endmodule

// [verification/tls_regs_props.sv]
// assertion checker for the trigger list status register bank
`timescale 1ns/1ns
module tls_regs_props (
   // clock and reset
   input wire logic                core_clk,
   input wire logic                rst,
   // apb slave side
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   // list fetch and unit outputs
   input wire tls_pkg::tls_fetch_s fetch,
   input wire tls_pkg::tls_fdata_s fdata,
   input wire logic                gen1_trigger,
   input wire logic                gen1_enable
);
   import tls_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // access phase in progress
   wire logic acc = psel && penable;

   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
   a_ready_in_time: assert property (acc && !pready |=> pready) else $error("pready late");
   a_ready_cause: assert property (pready |-> $past(acc)) else $error("pready without access");
   a_err_decode: assert property (pready |-> pslverr == (paddr > TLS_ADDR_STATUS
      || paddr[1:0] != 2'h0)) else $error("pslverr wrong");
   a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:24] == 8'h00)
      else $error("read data upper byte set");
   a_trig_pulse: assert property (gen1_trigger |=> !gen1_trigger) else $error("long trigger");
   a_trig_off: assert property (!gen1_enable && !$past(gen1_enable) |-> !gen1_trigger)
      else $error("trigger while disabled");
   a_fetch_hold: assert property (fetch.req && !fdata.valid |=> fetch.req &&
      $stable(fetch.addr)) else $error("fetch request dropped");
   a_enable_by_write: assert property ($changed(gen1_enable) |->
      $past(acc && pwrite) || $past(acc && pwrite, 2)) else $error("enable moved alone");
   // main scenarios reached
   c_trigger: cover property (gen1_trigger);
   c_slverr: cover property (pready && pslverr);
   c_eol: cover property (fdata.valid && fdata.data == TLS_EOL);
endmodule

// [verification/tls_mem.sv]
// list memory model answering the block's trigger value fetches
`timescale 1ns/1ns
module tls_mem (
   // clock and reset
   input wire logic                core_clk,
   input wire logic                rst,
   // fetch port, slow adds wait cycles
   input wire tls_pkg::tls_fetch_s fetch,
   input wire logic                slow,
   output tls_pkg::tls_fdata_s     fdata
);
   import tls_pkg::*;
   logic [15:0] mem [128]; // 16-bit words, loaded by the bench
   logic [1:0]  wait_q;    // latency counter
   // answer once per request; idle data toggles so stale values never match
   always_ff @(posedge core_clk) begin
      fdata.valid <= 1'b0;
      fdata.data  <= ~fdata.data;
      if (rst) begin
         wait_q <= 2'h0;
      end else if (fetch.req && !fdata.valid) begin
         wait_q <= wait_q + 2'h1;
         // only the 256-byte window is decoded
         if (!slow || wait_q == 2'h3) begin
            fdata.valid <= 1'b1;
            fdata.data  <= mem[fetch.addr[7:1]];
            wait_q      <= 2'h0;
         end
      end
   end
endmodule

// [verification/testbench.sv]
// self-checking testbench for the trigger list status register bank
`timescale 1ns/1ns
module testbench;
   import tls_pkg::*;
   // stimulus and observed signals
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv, c1;
   logic        pready, pslverr, ev, gen1_trigger, gen0_enable, gen1_enable;
   logic        reload = 1'b0, gen0_done = 1'b0, slow = 1'b0;
   tls_fetch_s  fetch;
   tls_fdata_s  fdata;
   int          n_mismatch = 0, num_checks = 0, ntrig = 0;

   always #20 core_clk = ~core_clk;
   // count trigger pulses as sampled on the edge
   always @(posedge core_clk) if (gen1_trigger === 1'b1) ntrig++;

   tls_regs i_tls_regs (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reload(reload), .gen0_done(gen0_done), .gen1_list1_offset(7'h30),
      .fetch(fetch), .fdata(fdata), .gen1_trigger(gen1_trigger),
      .gen0_enable(gen0_enable), .gen1_enable(gen1_enable));
   tls_mem i_tls_mem (.core_clk(core_clk), .rst(rst), .fetch(fetch), .slow(slow),
      .fdata(fdata));

   task automatic stop_test;
      if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a slave that never answers counts as a failure
      if (pready !== 1'b1) n_mismatch++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rv, ev);
      chk("write error", {31'h0, ev}, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0, rv, ev);
      chk(nm, rv, exp);
   endtask
   task automatic rel;
      @(posedge core_clk) reload <= 1'b1;
      @(posedge core_clk) reload <= 1'b0;
   endtask
   // poll status until generator one reports done, bounded
   task automatic wait_done;
      int k;
      k = 0;
      do begin
         apb(1'b0, TLS_ADDR_STATUS, 32'h0, rv, ev);
         k++;
      end while (rv[TLS_STAT_GEN1_DONE] !== 1'b1 && k < 200);
      chk("gen1 done", {31'h0, rv[TLS_STAT_GEN1_DONE]}, 32'h1);
   endtask

   // watchdog, far beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      stop_test();
   end

   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rd(TLS_ADDR_GEN1_LIST, 32'h0, "list");
      rd(TLS_ADDR_GEN1_COUNT, 32'h0, "count");
      rd(TLS_ADDR_BASE_PTR, 32'h0, "ptr");
      wr(TLS_ADDR_BASE_PTR, 32'h00123456);
      rd(TLS_ADDR_BASE_PTR, 32'h00123456, "ptr");
      wr(TLS_ADDR_G0L1_OFS, 32'h55);
      rd(TLS_ADDR_G0L1_OFS, 32'h55, "g0l1");
      wr(TLS_ADDR_G1L0_OFS, 32'h2A);
      rd(TLS_ADDR_G1L0_OFS, 32'h2A, "g1l0");
      wr(TLS_ADDR_GEN1_LIST, 32'h1);
      rd(TLS_ADDR_GEN1_LIST, 32'h1, "list");
      wr(TLS_ADDR_G0L0_OFS, 32'h7F);
      rd(TLS_ADDR_G0L0_OFS, 32'h0, "g0l0");
      wr(TLS_ADDR_COUNTER, 32'h1234);
      rd(TLS_ADDR_COUNTER, 32'h0, "counter");
      apb(1'b0, 8'h40, 32'h0, rv, ev);
      chk("slverr", {31'h0, ev}, 32'h1);
      // generator one enabled: pointer, its offset and list locked
      wr(TLS_ADDR_CTRL, 32'h2);
      chk("gen1 enable", {31'h0, gen1_enable}, 32'h1);
      chk("gen0 enable", {31'h0, gen0_enable}, 32'h0);
      wr(TLS_ADDR_BASE_PTR, 32'h0);
      rd(TLS_ADDR_BASE_PTR, 32'h00123456, "ptr lock");
      wr(TLS_ADDR_G1L0_OFS, 32'h0);
      rd(TLS_ADDR_G1L0_OFS, 32'h2A, "g1l0 lock");
      wr(TLS_ADDR_GEN1_LIST, 32'h0);
      rd(TLS_ADDR_GEN1_LIST, 32'h1, "list lock");
      wr(TLS_ADDR_G0L1_OFS, 32'h11);
      rd(TLS_ADDR_G0L1_OFS, 32'h11, "g0l1 open");
      // generator zero alone also locks the pointer
      wr(TLS_ADDR_CTRL, 32'h1);
      chk("gen0 enable", {31'h0, gen0_enable}, 32'h1);
      chk("gen1 enable", {31'h0, gen1_enable}, 32'h0);
      wr(TLS_ADDR_BASE_PTR, 32'h0);
      rd(TLS_ADDR_BASE_PTR, 32'h00123456, "ptr lock");
      wr(TLS_ADDR_G0L1_OFS, 32'h0);
      rd(TLS_ADDR_G0L1_OFS, 32'h11, "g0l1 lock");
      wr(TLS_ADDR_CTRL, 32'h0);
      wr(TLS_ADDR_BASE_PTR, 32'h0);
      wr(TLS_ADDR_G1L0_OFS, 32'h0);
      wr(TLS_ADDR_GEN1_LIST, 32'h0);
      // short list ended by the end symbol, slow memory
      i_tls_mem.mem[0] = 16'h0010;
      i_tls_mem.mem[1] = 16'h0020;
      i_tls_mem.mem[2] = 16'h0000;
      slow <= 1'b1; gen0_done <= 1'b1;
      wr(TLS_ADDR_CTRL, 32'h2);
      ntrig = 0;
      rel();
      wait_done();
      chk("triggers", 32'(ntrig), 32'h2);
      rd(TLS_ADDR_GEN1_COUNT, 32'h2, "count");
      rd(TLS_ADDR_GEN1_TVAL, 32'h0, "eol value");
      apb(1'b0, TLS_ADDR_COUNTER, 32'h0, c1, ev);
      rd(TLS_ADDR_COUNTER, c1, "halted");
      rel();
      rd(TLS_ADDR_GEN1_COUNT, 32'h0, "count clr");
      rd(TLS_ADDR_GEN1_TVAL, 32'h10, "first value");
      apb(1'b0, TLS_ADDR_COUNTER, 32'h0, c1, ev);
      apb(1'b0, TLS_ADDR_COUNTER, 32'h0, rv, ev);
      chk("restart", {31'h0, rv !== c1}, 32'h1);
      wait_done();
      // full list of thirty-two triggers, prompt memory
      wr(TLS_ADDR_CTRL, 32'h0);
      for (int k = 0; k < 33; k++) i_tls_mem.mem[k] = 16'(10 * (k + 1));
      slow <= 1'b0;
      wr(TLS_ADDR_CTRL, 32'h2);
      ntrig = 0;
      rel();
      wait_done();
      chk("triggers", 32'(ntrig), 32'h20);
      rd(TLS_ADDR_GEN1_COUNT, 32'h0, "count wrap");
      rd(TLS_ADDR_GEN1_TVAL, 32'h140, "last value");
      stop_test();
   end
endmodule

bind tls_regs tls_regs_props i_props (.core_clk(core_clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .fetch(fetch), .fdata(fdata), .gen1_trigger(gen1_trigger),
   .gen1_enable(gen1_enable));
